// *** design/osb_ordinary_space.sv ***
/*
 * Ordinary-space (SRAM style) access sequencer: setup idle, first access, wait,
 * second access and hold idle states, byte write strobes, access splitting,
 * external wait sampling and little-endian lane swapping for areas 2 and 4.
 * Assumes I_CLK runs at twice the external bus clock (O_BUS_CLK) so that falling-edge
 * events land on a core edge, aligned requests, and synchronous I_WAIT_N and I_D.
 */
`timescale 1ns/1ps

module osb_ordinary_space
    import osb_pkg::*;
#(
    parameter int LONG_WAIT_STEP = 2
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_REQ_VALID,
    input wire osb_req_t I_REQ,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output logic [31:0] O_RSP_RDATA,
    input wire osb_cfg_t I_CFG,
    input wire logic I_WAIT_N,
    input wire logic [31:0] I_D,
    output osb_pins_t O_PINS,
    output logic O_BUS_CLK
);

    initial begin
        if (LONG_WAIT_STEP < 1 || LONG_WAIT_STEP * 7 > int'(OSB_WAIT_MAX)) begin
            $error("LONG_WAIT_STEP must keep long waits within 1 to 14");
        end
    end

    typedef struct packed {
        osb_state_t st;
        logic ph;
        logic [3:0] cnt;
        logic [1:0] part;
        logic [1:0] last_part;
        logic [2:0] area;
        logic write;
        logic [2:0] wbytes;
        logic [2:0] pbytes;
        logic [1:0] size;
        logic [31:0] value;
        logic little;
        logic [31:0] acc;
        logic [3:0] waits;
        logic samp_en;
        logic wait_seen;
        logic [2:0] rel;
        logic [2:0] setup;
        logic [2:0] hold;
        logic burst;
        osb_pins_t pins;
        logic [31:0] rdata;
        logic rsp;
    } osb_regs_t;

    osb_regs_t r_ff;
    osb_regs_t nxt_r;

    function automatic logic [2:0] f_width_bytes(input logic [1:0] code);
        case (code)
            OSB_WID_8: f_width_bytes = 3'h1;
            OSB_WID_16: f_width_bytes = 3'h2;
            default: f_width_bytes = 3'h4;
        endcase
    endfunction

    function automatic logic [2:0] f_size_bytes(input logic [1:0] code);
        case (code)
            OSB_SZ_BYTE: f_size_bytes = 3'h1;
            OSB_SZ_WORD: f_size_bytes = 3'h2;
            default: f_size_bytes = 3'h4;
        endcase
    endfunction

    // Reverse byte order within the access size
    function automatic logic [31:0] f_byterev(input logic [31:0] v, input logic [1:0] size);
        case (size)
            OSB_SZ_BYTE: f_byterev = {24'h0, v[7:0]};
            OSB_SZ_WORD: f_byterev = {16'h0, v[7:0], v[15:8]};
            default: f_byterev = {v[7:0], v[15:8], v[23:16], v[31:24]};
        endcase
    endfunction

    // Lowest lane of a part: big-endian placement inside the device width
    function automatic logic [4:0] f_lane_shift(input osb_regs_t r);
        logic [2:0] off;
        off = 3'(r.pins.addr[1:0] & 2'(r.wbytes - 3'h1));
        f_lane_shift = {2'h0, 3'(r.wbytes - off - r.pbytes)} << 3;
    endfunction

    function automatic logic [31:0] f_part_mask(input logic [2:0] pbytes);
        case (pbytes)
            3'h1: f_part_mask = 32'h0000_00FF;
            3'h2: f_part_mask = 32'h0000_FFFF;
            default: f_part_mask = 32'hFFFF_FFFF;
        endcase
    endfunction

    // Load address and data lanes of part p, then enter its first state
    function automatic osb_regs_t f_start_part(input osb_regs_t r, input logic [1:0] p, input logic skip_setup);
        osb_regs_t o;
        logic [5:0] sh;
        o = r;
        o.part = p;
        o.pins.addr = OSB_ADDR_W'(r.pins.addr + OSB_ADDR_W'(r.pbytes) * OSB_ADDR_W'(p - r.part));
        sh = 6'({3'h0, r.pbytes} * {4'h0, 2'(r.last_part - p)}) << 3;
        o.pins.dout = ((r.value >> sh) & f_part_mask(r.pbytes)) << f_lane_shift(o);
        if (r.setup != 3'h0 && !skip_setup) begin
            o.st = OSB_SETUP_IDLE;
            o.cnt = {1'b0, r.setup};
        end else begin
            o.st = OSB_FIRST_ACCESS;
            o.cnt = 4'h1;
        end
        f_start_part = o;
    endfunction

    // Pin levels belonging to a state and phase
    function automatic osb_pins_t f_pins(input osb_regs_t n);
        osb_pins_t p;
        logic busy;
        logic more_burst;
        logic final_cyc;
        logic strobe;
        p = n.pins;
        busy = n.st != OSB_IDLE;
        more_burst = n.burst && n.part != n.last_part;
        final_cyc = (n.st == OSB_SECOND_ACCESS && n.cnt == 4'h1 && n.hold == 3'h0 && !more_burst)
            || (n.st == OSB_HOLD_IDLE && n.cnt == 4'h1 && n.part == n.last_part)
            || (n.st == OSB_HOLD_IDLE && n.cnt == 4'h1 && !n.burst);
        strobe = (n.st == OSB_FIRST_ACCESS || n.st == OSB_WAIT_STATE || n.st == OSB_SECOND_ACCESS)
            && !(n.st == OSB_SECOND_ACCESS && n.cnt == 4'h1 && n.ph);
        p.area_select_strobe_n = '1;
        if (busy && !(n.ph && final_cyc)) begin
            p.area_select_strobe_n[n.area] = 1'b0;
        end
        p.bus_start_strobe_n = !(n.st == OSB_FIRST_ACCESS);
        p.rd_n = !(strobe && !n.write);
        p.write_strobe_n = 4'hF;
        if (strobe && n.write) begin
            p.write_strobe_n = ~(4'((5'h1 << n.pbytes) - 5'h1) << (f_lane_shift(n) >> 3));
        end
        p.rd_wr = !(busy && n.write);
        p.dout_oe = busy && n.write && n.st != OSB_SETUP_IDLE;
        f_pins = p;
    endfunction

    always_comb begin
        logic [2:0] lw_idx;
        logic [3:0] lw_waits;
        logic [2:0] sbytes;
        logic [31:0] chunk;
        logic le_area;
        logic area4;
        nxt_r = r_ff;
        nxt_r.rsp = 1'b0;
        nxt_r.ph = !r_ff.ph;
        lw_idx = (I_REQ.area == OSB_AREA_EXT) ? 3'h3 : (I_REQ.area == 3'h3 ? 3'(OSB_LW_SHARED) : I_REQ.area);
        lw_waits = 4'(I_CFG.long_wait_field[lw_idx[1:0]] * LONG_WAIT_STEP);
        sbytes = f_size_bytes(I_REQ.size);
        le_area = I_REQ.area == OSB_AREA_LE_A || I_REQ.area == OSB_AREA_LE_B;
        area4 = I_REQ.area == OSB_AREA_EXT;
        chunk = ((I_D >> f_lane_shift(r_ff)) & f_part_mask(r_ff.pbytes));
        case (r_ff.st)
            OSB_IDLE: begin
                if (I_REQ_VALID && r_ff.ph) begin
                    nxt_r.area = I_REQ.area;
                    nxt_r.write = I_REQ.write;
                    nxt_r.size = I_REQ.size;
                    nxt_r.little = I_CFG.little_endian && le_area;
                    nxt_r.value = nxt_r.little ? f_byterev(I_REQ.wdata, I_REQ.size) : I_REQ.wdata;
                    nxt_r.wbytes = f_width_bytes(I_CFG.dev_width[I_REQ.area]);
                    nxt_r.pbytes = (sbytes < nxt_r.wbytes) ? sbytes : nxt_r.wbytes;
                    nxt_r.last_part = 2'((sbytes / nxt_r.pbytes) - 3'h1);
                    nxt_r.burst = I_CFG.ratio_one_to_one;
                    case (I_CFG.wait_field[I_REQ.area])
                        OSB_WF_NONE: nxt_r.waits = 4'h0;
                        OSB_WF_ONE: nxt_r.waits = 4'h1;
                        OSB_WF_TWO: nxt_r.waits = 4'h2;
                        default: nxt_r.waits = lw_waits;
                    endcase
                    nxt_r.samp_en = I_CFG.wait_field[I_REQ.area] != OSB_WF_NONE
                        && !I_CFG.ext_wait_mask[I_REQ.area];
                    nxt_r.rel = OSB_REL_1;
                    if (area4 && nxt_r.samp_en) begin
                        case (I_CFG.area4_release_delay)
                            2'h0: nxt_r.rel = OSB_REL_1;
                            2'h1: nxt_r.rel = OSB_REL_2;
                            default: nxt_r.rel = OSB_REL_4;
                        endcase
                    end
                    if (area4) begin
                        nxt_r.setup = I_CFG.area4_setup_idle_count;
                        nxt_r.hold = OSB_HOLD4_TBL[I_CFG.area4_hold_idle_count];
                    end else begin
                        nxt_r.setup = (3'(I_CFG.idle_extend[I_REQ.area[1:0]]) > OSB_IDLE_MAX_LOW) ?
                            OSB_IDLE_MAX_LOW : 3'(I_CFG.idle_extend[I_REQ.area[1:0]]);
                        nxt_r.hold = nxt_r.setup;
                    end
                    nxt_r.acc = 32'h0;
                    nxt_r.part = 2'h0;
                    nxt_r.pins.addr = I_REQ.addr;
                    nxt_r = f_start_part(nxt_r, 2'h0, 1'b0);
                end
            end
            OSB_SETUP_IDLE: begin
                if (r_ff.ph) begin
                    nxt_r.cnt = 4'(r_ff.cnt - 4'h1);
                    if (r_ff.cnt == 4'h1) begin
                        nxt_r.st = OSB_FIRST_ACCESS;
                    end
                end
            end
            OSB_FIRST_ACCESS: begin
                if (r_ff.ph) begin
                    nxt_r.wait_seen = 1'b0;
                    if (r_ff.waits != 4'h0) begin
                        nxt_r.st = OSB_WAIT_STATE;
                        nxt_r.cnt = r_ff.waits;
                    end else begin
                        nxt_r.st = OSB_SECOND_ACCESS;
                        nxt_r.cnt = 4'h1;
                    end
                end
            end
            OSB_WAIT_STATE: begin
                if (!r_ff.ph && r_ff.cnt == 4'h1) begin
                    nxt_r.wait_seen = r_ff.samp_en && !I_WAIT_N;
                end
                if (r_ff.ph) begin
                    if (r_ff.cnt != 4'h1) begin
                        nxt_r.cnt = 4'(r_ff.cnt - 4'h1);
                    end else if (!r_ff.wait_seen) begin
                        nxt_r.st = OSB_SECOND_ACCESS;
                        nxt_r.cnt = {1'b0, r_ff.rel};
                    end
                end
            end
            OSB_SECOND_ACCESS: begin
                if (!r_ff.ph && r_ff.cnt == 4'h1 && !r_ff.write) begin
                    nxt_r.acc = (r_ff.acc << ({2'h0, r_ff.pbytes} << 3)) | chunk;
                end
                if (r_ff.ph) begin
                    if (r_ff.cnt != 4'h1) begin
                        nxt_r.cnt = 4'(r_ff.cnt - 4'h1);
                    end else if (r_ff.burst && r_ff.part != r_ff.last_part) begin
                        nxt_r = f_start_part(r_ff, 2'(r_ff.part + 2'h1), 1'b1);
                        nxt_r.ph = 1'b0;
                    end else if (r_ff.hold != 3'h0) begin
                        nxt_r.st = OSB_HOLD_IDLE;
                        nxt_r.cnt = {1'b0, r_ff.hold};
                    end else if (r_ff.part != r_ff.last_part) begin
                        nxt_r = f_start_part(r_ff, 2'(r_ff.part + 2'h1), 1'b0);
                        nxt_r.ph = 1'b0;
                    end else begin
                        nxt_r.st = OSB_IDLE;
                        nxt_r.rsp = 1'b1;
                        nxt_r.rdata = r_ff.little ? f_byterev(nxt_r.acc, r_ff.size) : nxt_r.acc;
                    end
                end
            end
            OSB_HOLD_IDLE: begin
                if (r_ff.ph) begin
                    if (r_ff.cnt != 4'h1) begin
                        nxt_r.cnt = 4'(r_ff.cnt - 4'h1);
                    end else if (r_ff.part != r_ff.last_part) begin
                        nxt_r = f_start_part(r_ff, 2'(r_ff.part + 2'h1), 1'b0);
                        nxt_r.ph = 1'b0;
                    end else begin
                        nxt_r.st = OSB_IDLE;
                        nxt_r.rsp = 1'b1;
                        nxt_r.rdata = r_ff.little ? f_byterev(r_ff.acc, r_ff.size) : r_ff.acc;
                    end
                end
            end
            default: begin
                nxt_r.st = OSB_IDLE;
            end
        endcase
        nxt_r.pins = f_pins(nxt_r);
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            r_ff <= '0;
            r_ff.pins.area_select_strobe_n <= '1;
            r_ff.pins.bus_start_strobe_n <= 1'b1;
            r_ff.pins.rd_n <= 1'b1;
            r_ff.pins.write_strobe_n <= 4'hF;
            r_ff.pins.rd_wr <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign O_REQ_READY = r_ff.st == OSB_IDLE && r_ff.ph;
    assign O_RSP_VALID = r_ff.rsp;
    assign O_RSP_RDATA = r_ff.rdata;
    assign O_PINS = r_ff.pins;
    assign O_BUS_CLK = !r_ff.ph;

endmodule // osb_ordinary_space

// *** design/osb_pkg.sv ***
/*
 * Shared types and constants of the ordinary-space bus interface: access states,
 * request, configuration and pin carriers, field encodings and the area 4 hold idle-count table.
 * Assumes one core clock at twice the external bus clock; each bus cycle spans two core cycles.
 */
package osb_pkg;

    localparam int OSB_ADDR_W = 25;
    localparam int OSB_AREAS = 5;
    localparam int OSB_LW_AREAS = 4;
    localparam logic [2:0] OSB_AREA_LE_A = 3'h2;
    localparam logic [2:0] OSB_AREA_LE_B = 3'h4;
    localparam logic [2:0] OSB_AREA_EXT = 3'h4;
    localparam logic [1:0] OSB_LW_SHARED = 2'h2;

    // Device width codes
    localparam logic [1:0] OSB_WID_8 = 2'h0;
    localparam logic [1:0] OSB_WID_16 = 2'h1;
    localparam logic [1:0] OSB_WID_32 = 2'h2;

    // Access size codes
    localparam logic [1:0] OSB_SZ_BYTE = 2'h0;
    localparam logic [1:0] OSB_SZ_WORD = 2'h1;
    localparam logic [1:0] OSB_SZ_LONG = 2'h2;

    // Wait field codes
    localparam logic [1:0] OSB_WF_NONE = 2'h0;
    localparam logic [1:0] OSB_WF_ONE = 2'h1;
    localparam logic [1:0] OSB_WF_TWO = 2'h2;
    localparam logic [1:0] OSB_WF_LONG = 2'h3;

    localparam logic [3:0] OSB_WAIT_MAX = 4'hE;
    localparam logic [2:0] OSB_IDLE_MAX_LOW = 3'h2;
    localparam logic [2:0] OSB_REL_1 = 3'h1;
    localparam logic [2:0] OSB_REL_2 = 3'h2;
    localparam logic [2:0] OSB_REL_4 = 3'h4;
    // Area 4 hold idle count per two-bit code
    localparam logic [2:0] OSB_HOLD4_TBL [4] = '{3'h0, 3'h1, 3'h3, 3'h5};

    typedef enum logic [2:0] {
        OSB_IDLE = 3'b000,
        OSB_SETUP_IDLE = 3'b001,
        OSB_FIRST_ACCESS = 3'b010,
        OSB_WAIT_STATE = 3'b011,
        OSB_SECOND_ACCESS = 3'b100,
        OSB_HOLD_IDLE = 3'b101
    } osb_state_t;

    typedef struct packed {
        logic [2:0] area;
        logic write;
        logic [1:0] size;
        logic [OSB_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } osb_req_t;

    typedef struct packed {
        logic little_endian;
        logic ratio_one_to_one;
        logic [OSB_AREAS-1:0][1:0] dev_width;
        logic [OSB_AREAS-1:0][1:0] wait_field;
        logic [OSB_LW_AREAS-1:0][2:0] long_wait_field;
        logic [OSB_AREAS-1:0] ext_wait_mask;
        logic [1:0] area4_release_delay;
        logic [OSB_LW_AREAS-1:0][1:0] idle_extend;
        logic [2:0] area4_setup_idle_count;
        logic [1:0] area4_hold_idle_count;
    } osb_cfg_t;

    typedef struct packed {
        logic [OSB_AREAS-1:0] area_select_strobe_n;
        logic bus_start_strobe_n;
        logic rd_n;
        logic [3:0] write_strobe_n;
        logic rd_wr;
        logic [OSB_ADDR_W-1:0] addr;
        logic [31:0] dout;
        logic dout_oe;
    } osb_pins_t;

endpackage

// *** test/osb_bus_checker.sv ***
/*
 * Port checks of the ordinary-space sequencer: idle direction, start strobe,
 * strobe framing, setup quietness and no-wait latency.
 * Bound into the sequencer by the bench; sees only its ports.
 */
`timescale 1ns/1ps
module osb_bus_checker
    import osb_pkg::*;
#(
    parameter int LONG_WAIT_STEP = 2
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_REQ_VALID,
    input wire osb_req_t I_REQ,
    input wire logic O_REQ_READY,
    input wire logic O_RSP_VALID,
    input wire osb_cfg_t I_CFG,
    input wire osb_pins_t O_PINS,
    input wire logic O_BUS_CLK
);
    logic no_sel;
    logic no_strobe;
    assign no_sel = &O_PINS.area_select_strobe_n;
    assign no_strobe = O_PINS.rd_n && (&O_PINS.write_strobe_n);

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    chk_ready_idle: assert property (O_REQ_READY |-> no_sel && no_strobe && O_PINS.rd_wr)
        else $error("ready while bus not idle");
    chk_start_width: assert property ($fell(O_PINS.bus_start_strobe_n) |->
        !O_PINS.bus_start_strobe_n [*2] ##1 O_PINS.bus_start_strobe_n)
        else $error("start strobe not one bus cycle");
    chk_start_selected: assert property (!O_PINS.bus_start_strobe_n |-> !no_sel)
        else $error("start strobe without area select");
    chk_strobe_framed: assert property (!no_strobe |-> !no_sel)
        else $error("strobe outside area select");
    chk_nowait_len: assert property (I_REQ_VALID && O_REQ_READY && I_REQ.area == 3'h0 &&
        I_REQ.size == OSB_SZ_BYTE && I_CFG.wait_field[0] == OSB_WF_NONE && I_CFG.idle_extend[0] == 2'h0
        |-> ##1 !O_RSP_VALID [*4] ##1 O_RSP_VALID)
        else $error("no-wait access not two bus cycles");
    chk_read_no_write: assert property (!O_PINS.rd_n |-> (&O_PINS.write_strobe_n) && O_PINS.rd_wr)
        else $error("write strobe during read");
    chk_select_release: assert property ($rose(no_sel) && !$past(no_strobe) |-> !O_BUS_CLK && no_strobe)
        else $error("select released outside falling half");
    chk_setup_quiet: assert property ($fell(no_sel) && O_PINS.bus_start_strobe_n |-> no_strobe [*2])
        else $error("strobe during setup idle");
    chk_write_driven: assert property (!(&O_PINS.write_strobe_n) |-> O_PINS.dout_oe && !O_PINS.rd_wr)
        else $error("write strobe without driven data");
    chk_rsp_single: assert property (O_RSP_VALID |=> !O_RSP_VALID)
        else $error("response longer than one cycle");
endmodule // osb_bus_checker

// *** test/osb_ordinary_space_tb_top.sv ***
/*
 * Self-checking bench of the ordinary-space sequencer: timing, strobes, splitting,
 * waits, idle extension and lane swapping. Assumes the memory model and bound checker.
 */
`timescale 1ns/1ps
module osb_ordinary_space_tb_top import osb_pkg::*;;
    logic clk;
    logic arst_n;
    logic vld;
    osb_req_t req;
    osb_cfg_t cfg;
    logic rdy;
    logic rsp_vld;
    logic [31:0] rsp_data;
    logic wait_n;
    logic [31:0] d_in;
    osb_pins_t pins;
    logic [1:0] wid;
    logic [3:0] slow;
    logic oe_last;
    logic [31:0] r;
    int c;
    logic [24:0] addr_first;
    int bs_cnt;
    int rise_cnt;
    int err_total;
    int comparisons;

    osb_ordinary_space dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_REQ_VALID(vld), .I_REQ(req), .O_REQ_READY(rdy),
        .O_RSP_VALID(rsp_vld), .O_RSP_RDATA(rsp_data), .I_CFG(cfg), .I_WAIT_N(wait_n), .I_D(d_in),
        .O_PINS(pins), .O_BUS_CLK());
    osb_sram_model u_mem (.i_clk(clk), .i_pins(pins), .i_width(wid), .i_slow(slow), .o_wait_n(wait_n),
        .o_d(d_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if ($fell(pins.bus_start_strobe_n)) bs_cnt <= bs_cnt + 1;
        if ($fell(pins.bus_start_strobe_n) && bs_cnt == 0) addr_first <= pins.addr;
        if ($rose(&pins.area_select_strobe_n)) rise_cnt <= rise_cnt + 1;
        if (!(&pins.area_select_strobe_n)) oe_last <= pins.dout_oe;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One access; c is the cycle after the taking edge in which the response shows
    task automatic acc(input logic [2:0] ar, input logic wr, input logic [1:0] sz, input logic [24:0] ad,
        input logic [31:0] wd);
        int n;
        n = 0;
        c = 1;
        @(negedge clk);
        wid = cfg.dev_width[ar];
        req = '{area: ar, write: wr, size: sz, addr: ad, wdata: wd};
        bs_cnt = 0;
        rise_cnt = 0;
        vld = 1'b1;
        while (rdy !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        vld = 1'b0;
        while (rsp_vld !== 1'b1 && c < 60) begin
            @(negedge clk);
            c++;
        end
        chk(n >= 40 || c >= 60, 1'b0);
        r = rsp_data;
    endtask

    task automatic t_basic();
        acc(3'h0, 1'b1, OSB_SZ_LONG, 25'h10, 32'hA1B2C3D4);
        chk(c, 5);
        chk(u_mem.mem[8'h10], 8'hA1);
        acc(3'h0, 1'b1, OSB_SZ_BYTE, 25'h13, 32'h5E);
        chk({u_mem.mem[8'h12], u_mem.mem[8'h13]}, 16'hC35E);
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h11, 32'h0);
        chk(r, 32'hB2);
        chk(addr_first, 25'h11);
        chk(bs_cnt, 1);
    endtask

    task automatic t_split();
        cfg.dev_width[1] = OSB_WID_16;
        cfg.dev_width[3] = OSB_WID_8;
        acc(3'h1, 1'b1, OSB_SZ_LONG, 25'h20, 32'h01020304);
        chk(u_mem.mem[8'h21], 8'h02);
        chk({bs_cnt[3:0], rise_cnt[3:0]}, 8'h21);
        cfg.ratio_one_to_one = 1'b0;
        acc(3'h1, 1'b0, OSB_SZ_LONG, 25'h20, 32'h0);
        chk(r, 32'h01020304);
        chk(rise_cnt, 2);
        acc(3'h3, 1'b1, OSB_SZ_LONG, 25'h30, 32'hCAFEF00D);
        chk(bs_cnt, 4);
        acc(3'h3, 1'b0, OSB_SZ_WORD, 25'h32, 32'h0);
        chk(r, 32'hF00D);
        cfg.ratio_one_to_one = 1'b1;
        cfg.dev_width = {5{OSB_WID_32}};
    endtask

    task automatic t_endian();
        cfg.little_endian = 1'b1;
        cfg.dev_width[4] = OSB_WID_16;
        acc(3'h2, 1'b1, OSB_SZ_LONG, 25'h40, 32'h11223344);
        chk(u_mem.mem[8'h40], 8'h44);
        acc(3'h2, 1'b0, OSB_SZ_LONG, 25'h40, 32'h0);
        chk(r, 32'h11223344);
        acc(3'h4, 1'b1, OSB_SZ_WORD, 25'h50, 32'hAABB);
        chk(u_mem.mem[8'h50], 8'hBB);
        acc(3'h0, 1'b1, OSB_SZ_LONG, 25'h60, 32'h11223344);
        chk(u_mem.mem[8'h60], 8'h11);
        cfg.little_endian = 1'b0;
        acc(3'h2, 1'b1, OSB_SZ_LONG, 25'h44, 32'h11223344);
        chk(u_mem.mem[8'h44], 8'h11);
        cfg.dev_width[4] = OSB_WID_32;
    endtask

    task automatic t_waits();
        logic [2:0] rel [3] = '{3'h1, 3'h2, 3'h4};
        for (int k = 1; k < 3; k++) begin
            cfg.wait_field[0] = 2'(k);
            acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
            chk(c, 5 + 2 * k);
        end
        cfg.wait_field[0] = OSB_WF_LONG;
        cfg.long_wait_field[0] = 3'h7;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c, 33);
        cfg.wait_field[3] = OSB_WF_LONG;
        cfg.long_wait_field[OSB_LW_SHARED] = 3'h1;
        acc(3'h3, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c, 9);
        cfg.wait_field[0] = OSB_WF_TWO;
        slow = 4'h4;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c, 9);
        slow = 4'h8;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c > 9, 1'b1);
        cfg.ext_wait_mask[0] = 1'b1;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c, 9);
        cfg.wait_field[0] = OSB_WF_NONE;
        cfg.ext_wait_mask[0] = 1'b0;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
        chk(c, 5);
        slow = 4'h0;
        cfg.wait_field[4] = OSB_WF_ONE;
        for (int k = 0; k < 3; k++) begin
            cfg.area4_release_delay = 2'(k);
            acc(3'h4, 1'b0, OSB_SZ_BYTE, 25'h0, 32'h0);
            chk(c, 5 + 2 * rel[k]);
        end
        cfg.wait_field = '0;
    endtask

    task automatic t_idle();
        cfg.idle_extend[0] = 2'h2;
        acc(3'h0, 1'b1, OSB_SZ_BYTE, 25'h70, 32'h9);
        chk(c, 13);
        chk(oe_last, 1'b1);
        cfg.idle_extend[0] = 2'h1;
        acc(3'h0, 1'b0, OSB_SZ_BYTE, 25'h70, 32'h0);
        chk(c, 9);
        cfg.idle_extend[0] = 2'h0;
        cfg.area4_setup_idle_count = 3'h7;
        cfg.area4_hold_idle_count = 2'h3;
        acc(3'h4, 1'b1, OSB_SZ_BYTE, 25'h71, 32'h5);
        chk(c, 29);
    endtask

    initial begin
        arst_n = 1'b0;
        vld = 1'b0;
        req = '0;
        cfg = '0;
        cfg.ratio_one_to_one = 1'b1;
        cfg.dev_width = {5{OSB_WID_32}};
        wid = OSB_WID_32;
        slow = 4'h0;
        err_total = 0;
        comparisons = 0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        chk({pins.rd_wr, pins.rd_n, pins.dout_oe, &pins.area_select_strobe_n}, 4'hD);
        t_basic();
        t_split();
        t_endian();
        t_waits();
        t_idle();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule // osb_ordinary_space_tb_top

bind osb_ordinary_space osb_bus_checker #(.LONG_WAIT_STEP(LONG_WAIT_STEP)) u_chk (.I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY),
    .O_RSP_VALID(O_RSP_VALID), .I_CFG(I_CFG), .O_PINS(O_PINS), .O_BUS_CLK(O_BUS_CLK));

// *** test/osb_sram_model.sv ***
/*
 * Behavioural asynchronous memory on the ordinary-space pins, 256 bytes.
 * Assumes the lane width of the selected area on i_width; i_slow holds wait low.
 */
`timescale 1ns/1ps
module osb_sram_model
    import osb_pkg::*;
(
    input wire logic i_clk,
    input wire osb_pins_t i_pins,
    input wire logic [1:0] i_width,
    input wire logic [3:0] i_slow,
    output logic o_wait_n,
    output logic [31:0] o_d
);
    logic [7:0] mem [256];
    logic [5:0] cnt;
    logic [31:0] last = 32'h0;
    logic sel;

    assign sel = !(&i_pins.area_select_strobe_n);
    // Slow answer: wait held low for the first i_slow cycles of a select
    assign o_wait_n = !(sel && cnt < 6'(i_slow));

    function automatic logic [7:0] lane_idx(input int k);
        case (i_width)
            OSB_WID_32: return {i_pins.addr[7:2], 2'h0} + 8'(3 - k);
            OSB_WID_16: return {i_pins.addr[7:1], 1'h0} + 8'(1 - k);
            default: return i_pins.addr[7:0];
        endcase
    endfunction

    // Released lanes show the inverse of the last value
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_d[8*k +: 8] = (sel && !i_pins.rd_n && k < (1 << i_width)) ? mem[lane_idx(k)] : ~last[8*k +: 8];
        end
    end

    always @(posedge i_clk) begin
        last <= o_d;
        cnt <= sel ? cnt + 6'h1 : 6'h0;
        for (int k = 0; k < 4; k++) begin
            if (!i_pins.write_strobe_n[k]) mem[lane_idx(k)] <= i_pins.dout[8*k +: 8];
        end
    end
endmodule // osb_sram_model
